// ---- core/dwo_pkg.sv ----
// constants, types and address decode shared by the write-ordering router and its tracker
package dwo_pkg;

  // ***************************************************************
  // group, window and counter geometry
  // ***************************************************************
  localparam int GRP_N = 9;                          // master groups a..i
  localparam int GRP_W = 4;
  localparam logic [GRP_W-1:0] GRP_LIM = 4'h9;
  localparam int WIN_LSB = 11;                       // 2KB-aligned window for off-chip ordering
  localparam int WIN_W = 32 - WIN_LSB;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] PEND_MAX = 4'hf;      // pending external writes per group
  localparam logic [2:0] OUT_MAX = 3'h4;             // master requests in flight
  localparam logic [2:0] OUT_RST = 3'h0;
  localparam logic [6:0] DL_CYC = 7'h40;             // cycles of a closed wait before it is called a deadlock
  localparam logic [6:0] DL_RST = 7'h00;

  // ***************************************************************
  // memory map: cacheable external windows and local memories
  // ***************************************************************
  localparam logic [31:0] SHR_BASE = 32'h8000_0000;
  localparam logic [31:0] SHR_LAST = 32'h8001_ffff;
  localparam logic [31:0] AMI_BASE = 32'h4000_0000;
  localparam logic [31:0] AMI_LAST = 32'h67ff_ffff;
  localparam logic [31:0] DDR_BASE = 32'hc000_0000;
  localparam logic [31:0] DDR_LAST = 32'hcfff_ffff;
  localparam logic [31:0] L2_BASE = 32'h0080_0000;
  localparam logic [31:0] L2_LAST = 32'h0083_ffff;
  localparam logic [31:0] L1P_BASE = 32'h00e0_0000;
  localparam logic [31:0] L1P_LAST = 32'h00e0_7fff;
  localparam logic [31:0] L1D_BASE = 32'h00f0_0000;
  localparam logic [31:0] L1D_LAST = 32'h00f0_7fff;

  typedef enum logic [2:0] {DST_NONE, DST_L1D, DST_L1P, DST_L2, DST_EXT} dwo_dest_t;
  typedef enum logic [1:0] {CK_ALLOC, CK_VICTIM, CK_UNCACHED} dwo_ckind_t;

  // external windows that the caches may hold
  function automatic logic dwo_cacheable(input logic [31:0] a);
    return (a >= SHR_BASE && a <= SHR_LAST) || (a >= AMI_BASE && a <= AMI_LAST) ||
           (a >= DDR_BASE && a <= DDR_LAST);
  endfunction

  // local memories first, everything else leaves through the switch
  function automatic dwo_dest_t dwo_decode(input logic [31:0] a);
    if (a >= L1D_BASE && a <= L1D_LAST) return DST_L1D;
    if (a >= L1P_BASE && a <= L1P_LAST) return DST_L1P;
    if (a >= L2_BASE && a <= L2_LAST) return DST_L2;
    return DST_EXT;
  endfunction

endpackage

// ---- core/dwo_trk_if.sv ----
// carrier between the router and its per-group pending-write tracker
`timescale 1ns/1ps
interface dwo_trk_if;
  import dwo_pkg::*;
  logic wr_take;
  logic [GRP_W-1:0] wr_grp;
  logic [WIN_W-1:0] wr_win;
  logic done;
  logic [GRP_W-1:0] done_grp;
  logic [WIN_W-1:0] rd_win;
  logic [GRP_N-1:0] busy;
  logic [GRP_N-1:0] full;
  logic [GRP_N-1:0] hit;
  modport router (output wr_take, wr_grp, wr_win, done, done_grp, rd_win, input busy, full, hit);
  modport tracker (input wr_take, wr_grp, wr_win, done, done_grp, rd_win, output busy, full, hit);
endinterface

// ---- core/dwo_wr_tracker.sv ----
// per-group count and window of external writes still travelling through the switch
`timescale 1ns/1ps
module dwo_wr_tracker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  dwo_trk_if.tracker trk
);
  import dwo_pkg::*;

  // ***************************************************************
  // one counter, window and mixed flag per group
  // ***************************************************************
  for (genvar g = 0; g < GRP_N; g++) begin : g_grp
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [WIN_W-1:0] win_r;
    logic [WIN_W-1:0] win_nxt;
    logic mix_r;
    logic mix_nxt;
    logic inc;
    logic dec;

    // a second window while writes are pending makes the group block every off-chip read
    always_comb begin
      inc = trk.wr_take && trk.wr_grp == GRP_W'(g);
      dec = trk.done && trk.done_grp == GRP_W'(g) && cnt_r != '0;
      cnt_nxt = cnt_r + CNT_W'(inc) - CNT_W'(dec);
      win_nxt = inc ? trk.wr_win : win_r;
      mix_nxt = mix_r || (inc && cnt_r != '0 && trk.wr_win != win_r);
      if (cnt_nxt == '0) begin
        mix_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cnt_r <= '0;
        win_r <= '0;
        mix_r <= 1'b0;
      end else if (ce_i) begin
        cnt_r <= cnt_nxt;
        win_r <= win_nxt;
        mix_r <= mix_nxt;
      end
    end

    assign trk.busy[g] = cnt_r != '0;
    assign trk.full[g] = cnt_r == PEND_MAX;
    assign trk.hit[g] = mix_r || win_r == trk.rd_win; // writes in the read's window must drain, or all of them once the group's writes span two windows

    a_cnt_tracks_issue: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && inc && !dec |=> cnt_r == $past(cnt_r) + CNT_W'(1))
      else $error("pending count missed a write");
    a_window_hit_exact: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cnt_r != '0 && !mix_r && trk.rd_win != win_r |-> !trk.hit[g])
      else $error("read outside the window was held");
  end

endmodule

// ---- core/dwo_router.sv ----
// write-ordering router: slave and internal dma paths, master port queue, central switch entry
// Behaviour
// - slave port reaches level-1 data, level-1 program and level-2 memory for outside masters.
// - master port carries allocates, victim write-backs and uncached accesses beyond level 2.
// - shared ram, async memory interface and ddr windows count as cacheable.
// - level-1 data victims go to the level-2 controller, only then outward.
// - several master requests may be in flight at once.
// - level-1 dma accesses stall only when queued behind level-2 accesses.
// - internal dma stalls never count toward deadlock.
// - slave port drops ready when a level-2 access meets a pending write-back to cacheable external memory.
// - all group and write-back writes share one switch; older group writes may go first.
// - held slave write waiting on blocked switch traffic is flagged as deadlock.
// - a group read waits until that group's writes to the same destination finish.
// - off-chip reads wait for writes inside the same 2KB window, or for all of a group's writes once they span two windows.
// - all-cache level 2 or no level-2 dma traffic removes these stalls.
`timescale 1ns/1ps
module dwo_router (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic l2_all_cache_i,
  input wire logic slave_dma_port_valid_i,
  input wire logic slave_dma_port_wr_i,
  input wire logic [31:0] slave_dma_port_addr_i,
  input wire logic [dwo_pkg::GRP_W-1:0] slave_dma_port_grp_i,
  output logic slave_dma_port_ready_o,
  output dwo_pkg::dwo_dest_t slave_dma_port_dest_o,
  output logic slave_dma_port_acc_o,
  input wire logic internal_dma_engine_valid_i,
  input wire logic [31:0] internal_dma_engine_addr_i,
  output logic internal_dma_engine_ready_o,
  input wire logic l1d_victim_valid_i,
  input wire logic [31:0] l1d_victim_addr_i,
  output logic l1d_victim_ack_o,
  input wire logic cache_valid_i,
  input wire dwo_pkg::dwo_ckind_t cache_kind_i,
  input wire logic [31:0] cache_addr_i,
  output logic cache_ack_o,
  input wire logic master_dma_port_done_i,
  input wire logic grp_wr_valid_i,
  input wire logic [31:0] grp_wr_addr_i,
  input wire logic [dwo_pkg::GRP_W-1:0] grp_wr_grp_i,
  output logic grp_wr_ack_o,
  input wire logic grp_rd_valid_i,
  input wire logic [31:0] grp_rd_addr_i,
  input wire logic [dwo_pkg::GRP_W-1:0] grp_rd_grp_i,
  output logic grp_rd_ack_o,
  output logic sw_valid_o,
  output logic [31:0] sw_addr_o,
  output logic sw_is_master_dma_port_o,
  output dwo_pkg::dwo_ckind_t sw_kind_o,
  output logic [dwo_pkg::GRP_W-1:0] sw_grp_o,
  input wire logic sw_ready_i,
  input wire logic sw_done_i,
  input wire logic [dwo_pkg::GRP_W-1:0] sw_done_grp_i,
  output logic stall_o,
  output logic deadlock_o
);
  import dwo_pkg::*;

  dwo_trk_if trk ();

  dwo_wr_tracker u_trk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .trk(trk)
  );

  // ***************************************************************
  // state
  // ***************************************************************
  logic l2q_r, l2q_nxt, slave_dma_port_rdy_nxt;
  dwo_dest_t slave_dma_port_d, dest_nxt;
  logic mq_v_r, mq_v_nxt, mq_beh_r, mq_beh_nxt;
  logic [31:0] mq_addr_r, mq_addr_nxt;
  dwo_ckind_t mq_kind_r, mq_kind_nxt;
  logic vic_ack_nxt, cache_ack_nxt, gw_ack_nxt, rd_ack_nxt;
  logic sw_v_nxt, sw_master_dma_port_nxt;
  logic [31:0] sw_addr_nxt;
  dwo_ckind_t sw_kind_nxt;
  logic [GRP_W-1:0] sw_grp_nxt;
  logic [2:0] out_cnt_r, out_cnt_nxt;
  logic [6:0] dl_cnt_r, dl_cnt_nxt;
  logic dl_nxt, stall_nxt;
  logic slave_dma_port_take, internal_dma_engine_take, slave_dma_port_l2, internal_dma_engine_l2, wb_wait, l2_blocked;
  logic vic_ext, vic_take, cache_take, mq_free, mq_go, sw_free, gw_ok, pick_gw, rd_blk, dl_cond;

  // ***************************************************************
  // slave and internal dma paths
  // ***************************************************************
  // level 2 is held off only by a write-back aimed at cacheable external memory
  always_comb begin
    slave_dma_port_d = dwo_decode(slave_dma_port_addr_i);
    slave_dma_port_take = slave_dma_port_valid_i && slave_dma_port_ready_o;
    internal_dma_engine_take = internal_dma_engine_valid_i && internal_dma_engine_ready_o;
    slave_dma_port_l2 = slave_dma_port_valid_i && slave_dma_port_d == DST_L2;
    internal_dma_engine_l2 = internal_dma_engine_valid_i && dwo_decode(internal_dma_engine_addr_i) == DST_L2;
    wb_wait = mq_v_r && mq_kind_r == CK_VICTIM && dwo_cacheable(mq_addr_r);
    l2_blocked = !l2_all_cache_i && wb_wait;
    // an l2 access that meets the block parks the path; l1 accesses behind it wait too
    l2q_nxt = l2_blocked && (l2q_r || slave_dma_port_l2 || internal_dma_engine_l2);
    slave_dma_port_rdy_nxt = !l2q_nxt;
    dest_nxt = slave_dma_port_take ? slave_dma_port_d : DST_NONE;
    stall_nxt = slave_dma_port_valid_i && !slave_dma_port_ready_o;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      l2q_r <= 1'b0;
      slave_dma_port_ready_o <= 1'b1;
      internal_dma_engine_ready_o <= 1'b1;
      slave_dma_port_dest_o <= DST_NONE;
      slave_dma_port_acc_o <= 1'b0;
      stall_o <= 1'b0;
    end else if (ce_i) begin
      l2q_r <= l2q_nxt;
      slave_dma_port_ready_o <= slave_dma_port_rdy_nxt;
      internal_dma_engine_ready_o <= slave_dma_port_rdy_nxt;
      slave_dma_port_dest_o <= dest_nxt;
      slave_dma_port_acc_o <= slave_dma_port_take;
      stall_o <= stall_nxt;
    end
  end

  // ***************************************************************
  // master port queue: victims through level 2, then cache requests
  // ***************************************************************
  // victims of level-2 ram are absorbed locally, so they never load the queue
  always_comb begin
    vic_ext = dwo_decode(l1d_victim_addr_i) == DST_EXT;
    vic_take = l1d_victim_valid_i && !l1d_victim_ack_o && (!vic_ext || mq_free);
    cache_take = cache_valid_i && !cache_ack_o && mq_free && !(l1d_victim_valid_i && vic_ext);
    mq_v_nxt = mq_v_r && !mq_go;
    mq_addr_nxt = mq_addr_r;
    mq_kind_nxt = mq_kind_r;
    mq_beh_nxt = mq_beh_r;
    if (vic_take && vic_ext) begin
      mq_v_nxt = 1'b1;
      mq_addr_nxt = l1d_victim_addr_i;
      mq_kind_nxt = CK_VICTIM;
      mq_beh_nxt = grp_wr_valid_i && !grp_wr_ack_o;
    end else if (cache_take) begin
      mq_v_nxt = 1'b1;
      mq_addr_nxt = cache_addr_i;
      mq_kind_nxt = cache_kind_i;
      mq_beh_nxt = grp_wr_valid_i && !grp_wr_ack_o;
    end
    vic_ack_nxt = vic_take;
    cache_ack_nxt = cache_take;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mq_v_r <= 1'b0;
      mq_addr_r <= '0;
      mq_kind_r <= CK_ALLOC;
      mq_beh_r <= 1'b0;
      l1d_victim_ack_o <= 1'b0;
      cache_ack_o <= 1'b0;
    end else if (ce_i) begin
      mq_v_r <= mq_v_nxt;
      mq_addr_r <= mq_addr_nxt;
      mq_kind_r <= mq_kind_nxt;
      mq_beh_r <= mq_beh_nxt;
      l1d_victim_ack_o <= vic_ack_nxt;
      cache_ack_o <= cache_ack_nxt;
    end
  end

  // ***************************************************************
  // central switch entry, ordering tracker, deadlock watch
  // ***************************************************************
  // one slot feeds the switch; a group write already waiting when the master entry
  // arrived goes first, which is exactly what lets the closed wait form
  always_comb begin
    sw_free = !sw_valid_o || sw_ready_i;
    gw_ok = grp_wr_valid_i && !grp_wr_ack_o && grp_wr_grp_i < GRP_LIM && !trk.full[grp_wr_grp_i];
    pick_gw = sw_free && gw_ok && (!mq_v_r || mq_beh_r);
    mq_go = sw_free && mq_v_r && !pick_gw && out_cnt_r != OUT_MAX;
    mq_free = !mq_v_r || mq_go;
    sw_v_nxt = sw_valid_o && !sw_ready_i;
    sw_addr_nxt = sw_addr_o;
    sw_master_dma_port_nxt = sw_is_master_dma_port_o;
    sw_kind_nxt = sw_kind_o;
    sw_grp_nxt = sw_grp_o;
    if (pick_gw) begin
      sw_v_nxt = 1'b1;
      sw_addr_nxt = grp_wr_addr_i;
      sw_master_dma_port_nxt = 1'b0;
      sw_kind_nxt = CK_UNCACHED;
      sw_grp_nxt = grp_wr_grp_i;
    end else if (mq_go) begin
      sw_v_nxt = 1'b1;
      sw_addr_nxt = mq_addr_r;
      sw_master_dma_port_nxt = 1'b1;
      sw_kind_nxt = mq_kind_r;
      sw_grp_nxt = '0;
    end
    gw_ack_nxt = pick_gw;
    out_cnt_nxt = out_cnt_r + 3'(mq_go) - 3'(master_dma_port_done_i && out_cnt_r != OUT_RST);
    trk.wr_take = pick_gw;
    trk.wr_grp = grp_wr_grp_i;
    trk.wr_win = grp_wr_addr_i[31:WIN_LSB];
    trk.done = sw_done_i;
    trk.done_grp = sw_done_grp_i;
    trk.rd_win = grp_rd_addr_i[31:WIN_LSB];
    // local reads ride the in-order slave port; only a held write of the same group is ahead
    rd_blk = grp_rd_grp_i >= GRP_LIM ? 1'b0 :
      dwo_decode(grp_rd_addr_i) == DST_EXT ? (trk.busy[grp_rd_grp_i] && trk.hit[grp_rd_grp_i]) :
      (slave_dma_port_valid_i && slave_dma_port_wr_i && !slave_dma_port_ready_o && slave_dma_port_grp_i == grp_rd_grp_i);
    rd_ack_nxt = grp_rd_valid_i && !grp_rd_ack_o && !rd_blk;
    // only the slave write counts: an internal dma stall cannot close the loop
    dl_cond = slave_dma_port_valid_i && slave_dma_port_wr_i && !slave_dma_port_ready_o && wb_wait && sw_valid_o && !sw_is_master_dma_port_o && !sw_ready_i;
    dl_cnt_nxt = !dl_cond ? DL_RST : (dl_cnt_r == DL_CYC ? DL_CYC : dl_cnt_r + 7'h01);
    dl_nxt = dl_cnt_nxt == DL_CYC;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_valid_o <= 1'b0;
      sw_addr_o <= '0;
      sw_is_master_dma_port_o <= 1'b0;
      sw_kind_o <= CK_ALLOC;
      sw_grp_o <= '0;
      grp_wr_ack_o <= 1'b0;
      grp_rd_ack_o <= 1'b0;
      out_cnt_r <= OUT_RST;
      dl_cnt_r <= DL_RST;
      deadlock_o <= 1'b0;
    end else if (ce_i) begin
      sw_valid_o <= sw_v_nxt;
      sw_addr_o <= sw_addr_nxt;
      sw_is_master_dma_port_o <= sw_master_dma_port_nxt;
      sw_kind_o <= sw_kind_nxt;
      sw_grp_o <= sw_grp_nxt;
      grp_wr_ack_o <= gw_ack_nxt;
      grp_rd_ack_o <= rd_ack_nxt;
      out_cnt_r <= out_cnt_nxt;
      dl_cnt_r <= dl_cnt_nxt;
      deadlock_o <= dl_nxt;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_path_clear;
    ce_i && !l2q_r && !slave_dma_port_l2 && !internal_dma_engine_l2;
  endsequence
  sequence s_ext_victim_in;
    ce_i && vic_take && vic_ext;
  endsequence

  a_l1_no_stall: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_path_clear |=> slave_dma_port_ready_o && internal_dma_engine_ready_o)
    else $error("dma path stalled without level-2 traffic");
  a_all_cache_free: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && l2_all_cache_i |=> slave_dma_port_ready_o && !l2q_r)
    else $error("stall while level 2 is all cache");
  a_wb_holds_slave: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && l2_blocked && slave_dma_port_l2 && slave_dma_port_wr_i |=> !slave_dma_port_ready_o)
    else $error("slave write taken during external write-back");
  a_victim_outward: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_ext_victim_in |=> mq_v_r && mq_kind_r == CK_VICTIM && mq_addr_r == $past(l1d_victim_addr_i))
    else $error("victim not queued for the master port");
  a_group_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && sw_free && gw_ok && mq_v_r && mq_beh_r |=> sw_valid_o && !sw_is_master_dma_port_o ##0 grp_wr_ack_o)
    else $error("older group write not sent first");
  a_out_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && out_cnt_r == OUT_MAX && !master_dma_port_done_i |=> out_cnt_r == OUT_MAX && !$rose(sw_is_master_dma_port_o))
    else $error("master requests beyond the in-flight limit");
  a_deadlock_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && dl_cond && dl_cnt_r == DL_CYC - 7'h01 |=> deadlock_o)
    else $error("closed wait not flagged");
  a_dl_needs_slave: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && !(slave_dma_port_valid_i && slave_dma_port_wr_i) |=> !deadlock_o)
    else $error("deadlock flagged without a held slave write");
  a_read_waits: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && grp_rd_valid_i && rd_blk |=> !grp_rd_ack_o)
    else $error("read released ahead of pending writes");

endmodule

// ---- verification/dwo_sw_model.sv ----
// behavioural central switch beside the router: takes slots and reports completions
`timescale 1ns/1ps
module dwo_sw_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic hold_i,
  input wire logic sw_valid_i,
  input wire logic sw_is_master_dma_port_i,
  input wire logic [3:0] sw_grp_i,
  output logic sw_ready_o,
  output logic sw_done_o,
  output logic [3:0] sw_done_grp_o,
  output logic master_dma_port_done_o
);
  logic [4:0] q[$];
  logic [4:0] e;
  initial sw_done_o = 1'b0;
  initial master_dma_port_done_o = 1'b0;
  initial sw_done_grp_o = 4'h5;
  // a slow switch is one that withdraws ready; scenarios choose when
  assign sw_ready_o = !stall_i;
  // completions leave in take order, one a cycle, none while hold_i keeps writes pending
  always @(posedge clk_sys_i) begin
    sw_done_o <= 1'b0;
    master_dma_port_done_o <= 1'b0;
    sw_done_grp_o <= ~sw_done_grp_o; // group id is not valid between completions
    if (rst_i) begin
      q.delete();
    end else begin
      if (sw_valid_i && sw_ready_o) begin
        q.push_back({sw_is_master_dma_port_i, sw_grp_i});
      end
      if (!hold_i && q.size() > 0) begin
        e = q.pop_front();
        if (e[4]) begin
          master_dma_port_done_o <= 1'b1;
        end else begin
          sw_done_o <= 1'b1;
          sw_done_grp_o <= e[3:0];
        end
      end
    end
  end
endmodule

// ---- verification/dwo_router_tb.sv ----
// self-checking bench for the write-ordering router against a behavioural switch
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module dwo_router_tb;
  import dwo_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic l2_all_cache_i = 1'b0, stall = 1'b0, hold = 1'b0, got, seen;
  logic slave_dma_port_valid_i = 1'b0, slave_dma_port_wr_i = 1'b0, internal_dma_engine_valid_i = 1'b0, l1d_victim_valid_i = 1'b0;
  logic cache_valid_i = 1'b0, grp_wr_valid_i = 1'b0, grp_rd_valid_i = 1'b0;
  logic [31:0] slave_dma_port_addr_i = 32'h0, internal_dma_engine_addr_i = 32'h0, l1d_victim_addr_i = 32'h0, cache_addr_i = 32'h0;
  logic [31:0] grp_wr_addr_i = 32'h0, grp_rd_addr_i = 32'h0, sw_addr_o;
  logic [3:0] slave_dma_port_grp_i = 4'h0, grp_wr_grp_i = 4'h0, grp_rd_grp_i = 4'h0, sw_grp_o, sw_done_grp_i;
  dwo_ckind_t cache_kind_i = CK_ALLOC, sw_kind_o;
  dwo_dest_t slave_dma_port_dest_o;
  logic slave_dma_port_ready_o, slave_dma_port_acc_o, internal_dma_engine_ready_o, l1d_victim_ack_o, cache_ack_o, grp_wr_ack_o, grp_rd_ack_o;
  logic sw_valid_o, sw_is_master_dma_port_o, stall_o, deadlock_o, sw_ready_i, sw_done_i, master_dma_port_done_i;
  int bad_count = 0, compares = 0, n;
  // ordinary cases: slave port destinations, then master-port requests
  logic [31:0] DA[5] = '{32'h00f0_0010, 32'h00e0_7ffc, 32'h0080_0000, 32'h0083_fffc, 32'h0084_0000};
  dwo_dest_t DD[5] = '{DST_L1D, DST_L1P, DST_L2, DST_L2, DST_EXT};
  int CW[5] = '{0, 0, 0, 1, 1};
  dwo_ckind_t CK[5] = '{CK_ALLOC, CK_VICTIM, CK_UNCACHED, CK_VICTIM, CK_VICTIM};
  logic [31:0] CA[5] = '{32'hc000_1000, 32'h8000_0100, 32'h0100_0000, 32'h4000_2000, 32'h0080_0100};
  logic CS[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  dwo_router dwo_router_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .l2_all_cache_i(l2_all_cache_i),
    .slave_dma_port_valid_i(slave_dma_port_valid_i), .slave_dma_port_wr_i(slave_dma_port_wr_i), .slave_dma_port_addr_i(slave_dma_port_addr_i), .slave_dma_port_grp_i(slave_dma_port_grp_i),
    .slave_dma_port_ready_o(slave_dma_port_ready_o), .slave_dma_port_dest_o(slave_dma_port_dest_o), .slave_dma_port_acc_o(slave_dma_port_acc_o), .internal_dma_engine_valid_i(internal_dma_engine_valid_i),
    .internal_dma_engine_addr_i(internal_dma_engine_addr_i), .internal_dma_engine_ready_o(internal_dma_engine_ready_o), .l1d_victim_valid_i(l1d_victim_valid_i),
    .l1d_victim_addr_i(l1d_victim_addr_i), .l1d_victim_ack_o(l1d_victim_ack_o), .cache_valid_i(cache_valid_i),
    .cache_kind_i(cache_kind_i), .cache_addr_i(cache_addr_i), .cache_ack_o(cache_ack_o), .master_dma_port_done_i(master_dma_port_done_i),
    .grp_wr_valid_i(grp_wr_valid_i), .grp_wr_addr_i(grp_wr_addr_i), .grp_wr_grp_i(grp_wr_grp_i),
    .grp_wr_ack_o(grp_wr_ack_o), .grp_rd_valid_i(grp_rd_valid_i), .grp_rd_addr_i(grp_rd_addr_i),
    .grp_rd_grp_i(grp_rd_grp_i), .grp_rd_ack_o(grp_rd_ack_o), .sw_valid_o(sw_valid_o), .sw_addr_o(sw_addr_o),
    .sw_is_master_dma_port_o(sw_is_master_dma_port_o), .sw_kind_o(sw_kind_o), .sw_grp_o(sw_grp_o), .sw_ready_i(sw_ready_i),
    .sw_done_i(sw_done_i), .sw_done_grp_i(sw_done_grp_i), .stall_o(stall_o), .deadlock_o(deadlock_o));
  dwo_sw_model dwo_sw_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_i(stall), .hold_i(hold),
    .sw_valid_i(sw_valid_o), .sw_is_master_dma_port_i(sw_is_master_dma_port_o), .sw_grp_i(sw_grp_o), .sw_ready_o(sw_ready_i),
    .sw_done_o(sw_done_i), .sw_done_grp_o(sw_done_grp_i), .master_dma_port_done_o(master_dma_port_done_i));

  always #20 clk_sys_i = ~clk_sys_i;

  task stop_test;
    begin
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // slave (or internal) write; waits until taken, a dead cycle follows so valid never toggles in one step
  task dma_go(input logic use_i, input logic [31:0] a, input logic [3:0] g, input dwo_dest_t ed, output int k);
    begin
      k = 0;
      if (use_i) begin
        internal_dma_engine_valid_i = 1'b1;
        internal_dma_engine_addr_i = a;
      end else begin
        slave_dma_port_valid_i = 1'b1;
        slave_dma_port_wr_i = 1'b1;
        slave_dma_port_addr_i = a;
        slave_dma_port_grp_i = g;
      end
      while ((use_i ? internal_dma_engine_ready_o : slave_dma_port_ready_o) !== 1'b1 && k < 400) begin
        @(negedge clk_sys_i);
        k++;
      end
      @(negedge clk_sys_i);
      internal_dma_engine_valid_i = 1'b0;
      slave_dma_port_valid_i = 1'b0;
      if (!use_i) `CHK(slave_dma_port_acc_o, 1'b1)
      if (!use_i) `CHK(slave_dma_port_dest_o, ed)
      @(negedge clk_sys_i);
    end
  endtask

  // ack-handshake request: 0 cache, 1 victim, 2 group write, 3 group read
  task req(input int w, input dwo_ckind_t k, input logic [31:0] a, input logic [3:0] g, input int lim,
           output logic ok);
    int m;
    begin
      m = 0;
      ok = 1'b0;
      case (w)
        0: begin cache_valid_i = 1'b1; cache_kind_i = k; cache_addr_i = a; end
        1: begin l1d_victim_valid_i = 1'b1; l1d_victim_addr_i = a; end
        2: begin grp_wr_valid_i = 1'b1; grp_wr_addr_i = a; grp_wr_grp_i = g; end
        default: begin grp_rd_valid_i = 1'b1; grp_rd_addr_i = a; grp_rd_grp_i = g; end
      endcase
      while (!ok && m < lim) begin
        @(negedge clk_sys_i);
        m++;
        ok = ((w == 0) ? cache_ack_o : (w == 1) ? l1d_victim_ack_o : (w == 2) ? grp_wr_ack_o : grp_rd_ack_o) === 1'b1;
      end
      cache_valid_i = 1'b0;
      l1d_victim_valid_i = 1'b0;
      grp_wr_valid_i = 1'b0;
      grp_rd_valid_i = 1'b0;
      @(negedge clk_sys_i);
    end
  endtask

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    `CHK(slave_dma_port_ready_o, 1'b1)
    `CHK(internal_dma_engine_ready_o, 1'b1)
    `CHK(sw_valid_o, 1'b0)
    `CHK(slave_dma_port_dest_o, DST_NONE)
    `CHK(sw_kind_o, CK_ALLOC)
    `CHK(deadlock_o, 1'b0)
    @(negedge clk_sys_i);
    for (int i = 0; i < 5; i++) begin
      dma_go(1'b0, DA[i], 4'h0, DD[i], n);
      `CHK(n, 0)
    end
    // master-port requests leave through the switch, level-2 victims stay inside
    for (int i = 0; i < 5; i++) begin
      req(CW[i], CK[i], CA[i], 4'h0, 10, got);
      `CHK(got, 1'b1)
      for (n = 0; n < 6 && sw_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
      seen = sw_valid_o === 1'b1;
      `CHK(seen, CS[i])
      if (seen) `CHK(sw_kind_o, CK[i])
      if (seen) `CHK(sw_addr_o, CA[i])
      if (seen) `CHK(sw_is_master_dma_port_o, 1'b1)
      repeat (4) @(negedge clk_sys_i);
    end
    // no completions: four requests fill the in-flight budget, a fifth parks, a sixth is refused
    hold = 1'b1;
    for (int i = 0; i < 6; i++) begin
      req(0, CK_UNCACHED, 32'h0100_0000, 4'h0, 6, got);
      `CHK(got, (i < 5))
    end
    hold = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    // read ordering; group 1 has one external write pending, group 2 has none
    hold = 1'b1;
    req(2, CK_ALLOC, 32'hc000_0000, 4'h1, 10, got);
    `CHK(got, 1'b1)
    req(2, CK_ALLOC, 32'hc000_0000, 4'h9, 10, got);
    `CHK(got, 1'b0)
    repeat (3) @(negedge clk_sys_i);
    req(3, CK_ALLOC, 32'hc000_0010, 4'h1, 12, got);
    `CHK(got, 1'b0)
    req(3, CK_ALLOC, 32'hc000_0800, 4'h1, 10, got);
    `CHK(got, 1'b1)
    req(3, CK_ALLOC, 32'hc000_0000, 4'h2, 10, got);
    `CHK(got, 1'b1)
    req(3, CK_ALLOC, 32'h00f0_0000, 4'h1, 10, got);
    `CHK(got, 1'b1)
    hold = 1'b0;
    req(3, CK_ALLOC, 32'hc000_0010, 4'h1, 20, got);
    `CHK(got, 1'b1)
    // victim parked behind a group write at a slow switch: level-1 traffic runs free,
    // all-cache level 2 removes the refusal
    stall = 1'b1;
    req(2, CK_ALLOC, 32'h8000_0800, 4'h4, 10, got);
    `CHK(sw_grp_o, 4'h4)
    `CHK(sw_is_master_dma_port_o, 1'b0)
    `CHK(sw_kind_o, CK_UNCACHED)
    req(0, CK_VICTIM, 32'hc000_0040, 4'h0, 10, got);
    `CHK(got, 1'b1)
    dma_go(1'b0, 32'h00f0_0100, 4'h0, DST_L1D, n);
    `CHK(n, 0)
    l2_all_cache_i = 1'b1;
    repeat (2) begin
      dma_go(1'b0, 32'h0080_0200, 4'h0, DST_L2, n);
      `CHK(n, 0)
    end
    stall = 1'b0;
    l2_all_cache_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    // closed wait: group write in the slot, victim queued, slave write held, then the same with an internal dma write
    for (int s = 0; s < 2; s++) begin
      stall = 1'b1;
      req(2, CK_ALLOC, 32'h8000_0000, 4'h3, 10, got);
      req(0, CK_VICTIM, 32'h8000_0040, 4'h0, 10, got);
      dma_go(s[0], 32'h0080_0300, 4'h3, DST_L2, n);
      fork
        dma_go(s[0], 32'h0080_0400, 4'h3, DST_L2, n);
        begin
          repeat (3) @(negedge clk_sys_i);
          `CHK(slave_dma_port_ready_o, 1'b0)
          `CHK(internal_dma_engine_ready_o, 1'b0)
          if (s == 0) `CHK(stall_o, 1'b1)
          repeat (40) @(negedge clk_sys_i);
          `CHK(deadlock_o, 1'b0)
          repeat (40) @(negedge clk_sys_i);
          `CHK(deadlock_o, (s == 0))
          stall = 1'b0;
          repeat (2) @(negedge clk_sys_i);
          `CHK(deadlock_o, 1'b0)
        end
      join
      `CHK(n > 3, 1'b1)
      repeat (8) @(negedge clk_sys_i);
    end
    // reset in mid-run with a victim queued at a stalled switch
    stall = 1'b1;
    req(0, CK_VICTIM, 32'hc000_0080, 4'h0, 10, got);
    rst_i = 1'b1;
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    `CHK(sw_valid_o, 1'b0)
    `CHK(slave_dma_port_ready_o, 1'b1)
    stall = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    stop_test();
  end
endmodule
